// file: core/asp_defines.svh
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

// ----------------------------------------
// Register offsets (word index)
// ----------------------------------------
`define ASP_ADDR_CONTROL 2'h0
`define ASP_ADDR_BUFFER  2'h1
`define ASP_ADDR_POWER   2'h2
`define ASP_ADDR_TIMER2  2'h3

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASP_CTL_MODE_HI  7
`define ASP_CTL_MODE_LO  6
`define ASP_CTL_FILTER   5
`define ASP_CTL_RX_EN    4
`define ASP_CTL_TX_NINTH 3
`define ASP_CTL_RX_NINTH 2
`define ASP_CTL_TX_DONE  1
`define ASP_CTL_RX_DONE  0
`define ASP_PWR_DOUBLE   7
`define ASP_T2_RX_SEL    5
`define ASP_T2_TX_SEL    4

// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define ASP_CONTROL_RESET 8'h00
`define ASP_BUFFER_RESET  8'h00
`define ASP_RX_PRESET     9'h1FF
`define ASP_DIV_LAST      4'hF
`define ASP_SAMPLE_A      4'h6
`define ASP_SAMPLE_B      4'h7
`define ASP_SAMPLE_C      4'h8
`define ASP_FIX_SLOW_LAST 2'h3
`define ASP_TX_END_MASK   8'h01

`endif

// file: core/asp_pkg.sv
`default_nettype none
package asp_pkg;
  typedef enum logic [1:0] {
    ASP_MODE_SHIFT,
    ASP_MODE_10BIT,
    ASP_MODE_11FIX,
    ASP_MODE_11VAR
  } asp_mode_t;

  typedef enum logic [1:0] {
    ASP_RX_HUNT,
    ASP_RX_BITS,
    ASP_RX_TAIL
  } asp_rx_state_t;
endpackage
`default_nettype wire

// file: core/asp_link_if.sv
`default_nettype none
interface asp_link_if;
  logic dev_txd;
  logic dev_rxd;

  modport dev (output dev_txd, input dev_rxd);
  modport peer (input dev_txd, output dev_rxd);
endinterface
`default_nettype wire

// file: core/asp_serial_port.sv
// The register offsets and the address-and-strobe port were chosen for this implementation.
`include "asp_defines.svh"
`default_nettype none
module asp_serial_port
  import asp_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output var  logic [7:0] reg_rdata,
  input  wire logic       timer1_overflow,
  input  wire logic       timer2_overflow,
  output var  logic       serial_irq,
  asp_link_if.dev         link
);

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [1:0]    mode_sel;
  logic          multiproc_filter;
  logic          rx_enable;
  logic          tx_ninth_bit;
  logic          rx_ninth_bit;
  logic          tx_done_flag;
  logic          rx_done_flag;
  logic [7:0]    serial_buffer;
  logic          baud_double;
  logic          tx_clk_select;
  logic          rx_clk_select;
  asp_mode_t     mode;
  logic          wr_ctrl;
  logic          wr_buf;
  logic          tx_set;
  logic          rx_accept;
  logic          rx_vote;

  assign mode    = asp_mode_t'(mode_sel);
  assign wr_ctrl = reg_wr && (reg_addr == `ASP_ADDR_CONTROL);
  assign wr_buf  = reg_wr && (reg_addr == `ASP_ADDR_BUFFER);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_sel         <= 2'h0;
      multiproc_filter <= 1'b0;
      rx_enable        <= 1'b0;
      tx_ninth_bit     <= 1'b0;
    end else if (wr_ctrl) begin
      mode_sel         <= reg_wdata[`ASP_CTL_MODE_HI:`ASP_CTL_MODE_LO];
      multiproc_filter <= reg_wdata[`ASP_CTL_FILTER];
      rx_enable        <= reg_wdata[`ASP_CTL_RX_EN];
      tx_ninth_bit     <= reg_wdata[`ASP_CTL_TX_NINTH];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      baud_double   <= 1'b0;
      tx_clk_select <= 1'b0;
      rx_clk_select <= 1'b0;
    end else if (reg_wr && reg_addr == `ASP_ADDR_POWER) begin
      baud_double   <= reg_wdata[`ASP_PWR_DOUBLE];
    end else if (reg_wr && reg_addr == `ASP_ADDR_TIMER2) begin
      tx_clk_select <= reg_wdata[`ASP_T2_TX_SEL];
      rx_clk_select <= reg_wdata[`ASP_T2_RX_SEL];
    end
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      rx_ninth_bit <= 1'b0;
    end else begin
      if (tx_set) tx_done_flag <= 1'b1;
      else if (wr_ctrl) tx_done_flag <= reg_wdata[`ASP_CTL_TX_DONE];
      if (rx_accept) rx_done_flag <= 1'b1;
      else if (wr_ctrl) rx_done_flag <= reg_wdata[`ASP_CTL_RX_DONE];
      if (rx_accept) rx_ninth_bit <= rx_vote;
      else if (wr_ctrl) rx_ninth_bit <= reg_wdata[`ASP_CTL_RX_NINTH];
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata  <= 8'h00;
      serial_irq <= 1'b0;
    end else begin
      serial_irq <= rx_done_flag | tx_done_flag;
      reg_rdata  <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `ASP_ADDR_CONTROL: reg_rdata <= {mode_sel, multiproc_filter,
            rx_enable, tx_ninth_bit, rx_ninth_bit, tx_done_flag,
            rx_done_flag};
          `ASP_ADDR_BUFFER: reg_rdata <= serial_buffer;
          `ASP_ADDR_POWER: reg_rdata <= {baud_double, 7'h00};
          default: reg_rdata <= {2'h0, rx_clk_select, tx_clk_select,
            4'h0};
        endcase
      end
    end
  end

  // ----------------------------------------
  // Sixteen-times bit-rate ticks
  // ----------------------------------------
  logic [1:0] fix_cnt;
  logic       fix_tick;
  logic       t1_half;
  logic       t1_tick;
  logic       tx_tick;
  logic       rx_tick;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) fix_cnt <= 2'h0;
    else fix_cnt <= fix_cnt + 2'h1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) t1_half <= 1'b0;
    else if (timer1_overflow) t1_half <= ~t1_half;
  end

  // Osc/4 or osc/2 tick gives 1/64 or 1/32 bit rate
  assign fix_tick = baud_double ? fix_cnt[0]
                                : (fix_cnt == `ASP_FIX_SLOW_LAST);
  assign t1_tick  = timer1_overflow && (baud_double || t1_half);

  always_comb begin
    case (mode)
      ASP_MODE_SHIFT: begin
        tx_tick = 1'b0;
        rx_tick = 1'b0;
      end
      ASP_MODE_11FIX: begin
        tx_tick = fix_tick;
        rx_tick = fix_tick;
      end
      default: begin
        tx_tick = tx_clk_select ? timer2_overflow : t1_tick;
        rx_tick = rx_clk_select ? timer2_overflow : t1_tick;
      end
    endcase
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  logic [8:0] tsr;
  logic [3:0] tx_div;
  logic       tx_req;
  logic       tx_send;
  logic       tx_data_en;
  logic       tx_shifted;
  logic       tx_roll;
  logic       tx_last;
  logic       tx_insert;

  assign tx_roll   = tx_tick && (tx_div == `ASP_DIV_LAST);
  assign tx_last   = tx_shifted && (tsr[8:1] == `ASP_TX_END_MASK);
  assign tx_insert = (mode != ASP_MODE_10BIT) && !tx_shifted;
  assign tx_set    = tx_roll && tx_send && tx_data_en && tx_last;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) tx_div <= 4'h0;
    else if (tx_tick) tx_div <= tx_div + 4'h1;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tsr        <= 9'h000;
      tx_req     <= 1'b0;
      tx_send    <= 1'b0;
      tx_data_en <= 1'b0;
      tx_shifted <= 1'b0;
    end else if (wr_buf) begin
      tsr <= {(mode == ASP_MODE_10BIT) ? 1'b1 : tx_ninth_bit,
              reg_wdata};
      tx_req     <= 1'b1;
      tx_send    <= 1'b0;
      tx_data_en <= 1'b0;
      tx_shifted <= 1'b0;
    end else if (tx_roll) begin
      if (tx_req) begin
        tx_req  <= 1'b0;
        tx_send <= 1'b1;
      end else if (tx_send && !tx_data_en) begin
        tx_data_en <= 1'b1;
      end else if (tx_send) begin
        tsr        <= {tx_insert, tsr[8:1]};
        tx_shifted <= 1'b1;
        if (tx_last) begin
          tx_send    <= 1'b0;
          tx_data_en <= 1'b0;
        end
      end
    end
  end

  // Idle line level doubles as the stop bit
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) link.dev_txd <= 1'b1;
    else if (!tx_send) link.dev_txd <= 1'b1;
    else if (!tx_data_en) link.dev_txd <= 1'b0;
    else link.dev_txd <= tsr[0];
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  asp_rx_state_t rx_state;
  logic [3:0]    rx_div;
  logic [8:0]    rsr;
  logic [1:0]    rx_samp;
  logic          rx_prev;
  logic          rx_first;
  logic          rx_final;
  logic [7:0]    rx_byte;

  assign rx_vote = (rx_samp[1] & rx_samp[0]) | (rx_samp[1] & link.dev_rxd)
                 | (rx_samp[0] & link.dev_rxd);
  assign rx_final = rx_tick && (rx_state == ASP_RX_BITS)
                 && (rx_div == `ASP_SAMPLE_C) && !rx_first && !rsr[8];
  // Same test serves both frame lengths; in 10-bit mode the bit it samples is the stop bit
  assign rx_accept = rx_final && !rx_done_flag
                  && (!multiproc_filter || rx_vote);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_rev
      assign rx_byte[gi] = rsr[7 - gi];
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) serial_buffer <= `ASP_BUFFER_RESET;
    else if (rx_accept) serial_buffer <= rx_byte;
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_state <= ASP_RX_HUNT;
      rx_div   <= 4'h0;
      rsr      <= `ASP_RX_PRESET;
      rx_samp  <= 2'h0;
      rx_prev  <= 1'b1;
      rx_first <= 1'b0;
    end else if (rx_tick) begin
      rx_prev <= link.dev_rxd;
      case (rx_state)
        ASP_RX_HUNT: begin
          if (rx_enable && rx_prev && !link.dev_rxd) begin
            rx_div   <= 4'h0;
            rsr      <= `ASP_RX_PRESET;
            rx_first <= 1'b1;
            rx_state <= ASP_RX_BITS;
          end
        end
        ASP_RX_BITS: begin
          rx_div <= rx_div + 4'h1;
          if (rx_div == `ASP_SAMPLE_A) rx_samp[1] <= link.dev_rxd;
          if (rx_div == `ASP_SAMPLE_B) rx_samp[0] <= link.dev_rxd;
          if (rx_div == `ASP_SAMPLE_C) begin
            rx_first <= 1'b0;
            if (rx_first && rx_vote) begin
              rx_state <= ASP_RX_HUNT;
            end else if (rx_final) begin
              rsr <= {rsr[7:0], rx_vote};
              rx_state <= (mode == ASP_MODE_10BIT) ? ASP_RX_HUNT
                                                   : ASP_RX_TAIL;
            end else begin
              rsr <= {rsr[7:0], rx_vote};
            end
          end
        end
        ASP_RX_TAIL: begin
          rx_div <= rx_div + 4'h1;
          if (rx_div == `ASP_SAMPLE_C) rx_state <= ASP_RX_HUNT;
        end
        default: rx_state <= ASP_RX_HUNT;
      endcase
    end
  end

endmodule
`default_nettype wire

// file: core/asp_peer.sv
`include "asp_defines.svh"
`default_nettype none
module asp_peer
  import asp_pkg::*;
#(
  parameter int BIT_CYCLES = 64
) (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic       long_frame,
  input  wire logic       send_strobe,
  input  wire logic [7:0] send_data,
  input  wire logic       send_ninth,
  output var  logic       send_busy,
  output var  logic [7:0] recv_data,
  output var  logic       recv_ninth,
  output var  logic       recv_valid,
  output var  logic       recv_stop_err,
  asp_link_if.peer        link
);

  // Counters are 16 bits; tiny bit times break mid-bit sampling
  if (BIT_CYCLES < 4 || BIT_CYCLES > 65535) begin : g_bad_bits
    $error("BIT_CYCLES out of range");
  end

  // ----------------------------------------
  // Transmit side
  // ----------------------------------------
  logic [10:0] tx_sr;
  logic [3:0]  tx_left;
  logic [15:0] tx_cnt;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_sr        <= 11'h7FF;
      tx_left      <= 4'h0;
      tx_cnt       <= 16'h0000;
      send_busy    <= 1'b0;
      link.dev_rxd <= 1'b1;
    end else if (!send_busy) begin
      if (send_strobe) begin
        // Start low, data LSB first, optional ninth, stop high
        tx_sr <= long_frame ? {1'b1, send_ninth, send_data, 1'b0}
                            : {2'h3, send_data, 1'b0};
        tx_left   <= long_frame ? 4'hB : 4'hA;
        tx_cnt    <= 16'h0000;
        send_busy <= 1'b1;
      end
    end else if (tx_cnt == 16'(BIT_CYCLES - 1) || tx_left == 4'h0) begin
      tx_cnt <= 16'h0000;
      if (tx_left == 4'h0) begin
        send_busy    <= 1'b0;
        link.dev_rxd <= 1'b1;
      end else begin
        link.dev_rxd <= tx_sr[0];
        tx_sr        <= {1'b1, tx_sr[10:1]};
        tx_left      <= tx_left - 4'h1;
      end
    end else begin
      tx_cnt <= tx_cnt + 16'h0001;
    end
  end

  // ----------------------------------------
  // Receive side: one sample mid-bit
  // ----------------------------------------
  logic [9:0]  rx_sr;
  logic [3:0]  rx_left;
  logic [15:0] rx_cnt;
  logic        rx_busy;
  logic        rx_prev;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_sr         <= 10'h000;
      rx_left       <= 4'h0;
      rx_cnt        <= 16'h0000;
      rx_busy       <= 1'b0;
      rx_prev       <= 1'b1;
      recv_data     <= 8'h00;
      recv_ninth    <= 1'b0;
      recv_valid    <= 1'b0;
      recv_stop_err <= 1'b0;
    end else begin
      rx_prev    <= link.dev_txd;
      recv_valid <= 1'b0;
      if (!rx_busy) begin
        if (rx_prev && !link.dev_txd) begin
          rx_busy <= 1'b1;
          rx_cnt  <= 16'(BIT_CYCLES / 2);
          rx_left <= long_frame ? 4'hB : 4'hA;
        end
      end else if (rx_cnt == 16'(BIT_CYCLES - 1)) begin
        rx_cnt  <= 16'h0000;
        rx_left <= rx_left - 4'h1;
        rx_sr   <= {link.dev_txd, rx_sr[9:1]};
        if (rx_left == 4'h1) begin
          rx_busy       <= 1'b0;
          recv_valid    <= 1'b1;
          recv_stop_err <= !link.dev_txd;
          recv_data     <= long_frame ? rx_sr[8:1] : rx_sr[9:2];
          recv_ninth    <= long_frame ? rx_sr[9] : link.dev_txd;
        end
      end else begin
        rx_cnt <= rx_cnt + 16'h0001;
      end
    end
  end

endmodule
`default_nettype wire

// file: verification/asp_link_checker.sv
`default_nettype none
module asp_link_checker #(
  parameter int BIT_CYCLES = 64
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic dev_txd,
  input wire logic dev_rxd
);
  // ------------
  // Run lengths
  // ------------
  // 16 bits: an idle run past that wraps, so keep runs short
  logic [15:0] lo_t, hi_t, lo_r, hi_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lo_t <= '0;
      hi_t <= '0;
      lo_r <= '0;
      hi_r <= '0;
    end else begin
      lo_t <= dev_txd ? '0 : lo_t + 16'h1;
      hi_t <= dev_txd ? hi_t + 16'h1 : '0;
      lo_r <= dev_rxd ? '0 : lo_r + 16'h1;
      hi_r <= dev_rxd ? hi_r + 16'h1 : '0;
    end
  end

  // ------------
  // Framing
  // ------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  sequence s_txd_start;
    !dev_txd [*8];
  endsequence
  sequence s_rxd_start;
    !dev_rxd [*8];
  endsequence

  a_idle_reset: assert property ($rose(rstn) |-> dev_txd & dev_rxd)
    else $error("line not idle after reset");
  a_txd_start: assert property ($fell(dev_txd) |-> s_txd_start)
    else $error("txd start bit too short");
  a_txd_bit_len: assert property (
    $rose(dev_txd) |-> lo_t % BIT_CYCLES == 0)
    else $error("txd low run not whole bits");
  a_txd_low_max: assert property (lo_t <= 10 * BIT_CYCLES)
    else $error("txd low too long for a frame");
  a_txd_stop: assert property (
    $fell(dev_txd) |-> hi_t >= BIT_CYCLES)
    else $error("txd stop bit too short");
  a_rxd_start: assert property ($fell(dev_rxd) |-> s_rxd_start)
    else $error("rxd start bit too short");
  a_rxd_bit_len: assert property (
    $rose(dev_rxd) |-> lo_r % BIT_CYCLES == 0)
    else $error("rxd low run not whole bits");
  a_rxd_low_max: assert property (lo_r <= 10 * BIT_CYCLES)
    else $error("rxd low too long for a frame");
  a_rxd_stop: assert property (
    $fell(dev_rxd) |-> hi_r >= BIT_CYCLES)
    else $error("rxd stop bit too short");
endmodule
`default_nettype wire

// file: verification/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------
  // Wiring
  // ------------
  logic       sys_clk;
  logic       rstn = 1'b0;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       timer1_overflow = 1'b0;
  logic       timer2_overflow = 1'b0;
  logic       long_frame = 1'b0;
  logic       send_strobe = 1'b0;
  logic [7:0] send_data = 8'h00;
  logic       send_ninth = 1'b0;
  logic       raw_rxd = 1'b1;
  logic       t1_on = 1'b0;
  logic       t2_on = 1'b0;
  logic [1:0] tick_div = 2'h0;
  logic [7:0] reg_rdata, rdata2, recv_data, ctl;
  logic       serial_irq, irq2, send_busy, recv_ninth;
  logic       recv_valid, recv_stop_err;
  int         miscompares = 0;
  int         num_checks = 0;

  asp_link_if lk ();
  asp_link_if lk2 ();
  assign lk2.dev_rxd = raw_rxd;

  asp_serial_port asp_serial_port_i (
    .sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .timer1_overflow, .timer2_overflow, .serial_irq,
    .link (lk.dev)
  );
  // Second device: its receive line is driven raw by the bench
  asp_serial_port asp_serial_port_i2 (
    .sys_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata (rdata2), .timer1_overflow, .timer2_overflow,
    .serial_irq (irq2), .link (lk2.dev)
  );
  asp_peer #(.BIT_CYCLES(64)) asp_peer_i (
    .sys_clk, .rstn, .long_frame, .send_strobe, .send_data, .send_ninth,
    .send_busy, .recv_data, .recv_ninth, .recv_valid, .recv_stop_err,
    .link (lk.peer)
  );
  asp_link_checker #(.BIT_CYCLES(64)) asp_link_checker_i (
    .sys_clk, .rstn, .dev_txd (lk.dev_txd), .dev_rxd (lk.dev_rxd)
  );

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Overflow every 4 clocks: 64 clocks a bit, same as the peer
  always @(posedge sys_clk) begin
    tick_div <= tick_div + 2'h1;
    timer1_overflow <= t1_on && tick_div == 2'h3;
    timer2_overflow <= t2_on && tick_div == 2'h3;
  end

  // ------------
  // Tasks
  // ------------
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic wr(logic [1:0] a, logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(logic [1:0] a, output logic [7:0] v, v2);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
    v2 = rdata2;
  endtask

  task automatic tx_frame(logic [7:0] d, logic nine, int nb);
    int n, f, i;
    logic [10:0] got;
    logic [7:0] v, v2;
    n = 0;
    f = 0;
    i = 0;
    got = '0;
    wr(2'h1, d);
    while (n < 1000 && !(i > 0 && got[10])) begin
      @(posedge sys_clk) #1;
      n++;
      if (f == 0 && lk.dev_txd === 1'b0) f = n;
      if (i == 0 && serial_irq === 1'b1) i = n;
      if (recv_valid === 1'b1) got = {2'b10, recv_ninth, recv_data};
      if (recv_valid === 1'b1) got[9] = recv_stop_err;
    end
    chk("tx start", 1, f > 0 && f <= 66);
    chk("tx done", 1, i > (nb - 1) * 64 && i <= nb * 64 + 3);
    chk("peer frame", {2'b10, nine, d}, got);
    rd(2'h0, v, v2);
    chk("tx flag", 1, v[1]);
    wr(2'h0, ctl);
    @(posedge sys_clk) #1;
    chk("irq clear", 0, serial_irq);
  endtask

  task automatic rx_frame(logic [7:0] d, logic nine, logic e_ri,
                          logic [7:0] e_buf, logic e_rb8);
    int n;
    logic [7:0] v, v2;
    n = 0;
    @(posedge sys_clk);
    send_data <= d;
    send_ninth <= nine;
    send_strobe <= 1'b1;
    @(posedge sys_clk);
    send_strobe <= 1'b0;
    @(posedge sys_clk) #1;
    while (n < 1000 && send_busy !== 1'b0) begin
      @(posedge sys_clk) #1;
      n++;
    end
    // Busy drops as the stop bit starts; 10-bit accept is mid-stop
    repeat (64) @(posedge sys_clk);
    rd(2'h0, v, v2);
    chk("rx flag", e_ri, v[0]);
    chk("rx ninth", e_rb8, v[2]);
    rd(2'h1, v, v2);
    chk("rx byte", e_buf, v);
  endtask

  // ------------
  // Scenarios
  // ------------
  task automatic s_reset();
    logic [7:0] v, v2;
    for (int a = 0; a < 4; a++) begin
      rd(a[1:0], v, v2);
      chk("reset reg", 16'h0000, v);
    end
    chk("reset irq", 0, serial_irq);
    $display("reset test done");
  endtask

  task automatic s_mode1();
    t1_on <= 1'b1;
    ctl = 8'h50;
    wr(2'h2, 8'h80);
    wr(2'h0, ctl);
    tx_frame(8'hA5, 1'b1, 10);
    rx_frame(8'h3C, 1'b0, 1'b1, 8'h3C, 1'b1);
    rx_frame(8'h55, 1'b0, 1'b1, 8'h3C, 1'b1);
    wr(2'h0, ctl);
    @(posedge sys_clk) #1;
    chk("irq off", 0, serial_irq);
    wr(2'h0, 8'h52);
    @(posedge sys_clk) #1;
    chk("irq on", 1, serial_irq);
    wr(2'h0, ctl);
    $display("10-bit test done");
  endtask

  task automatic s_mode2();
    t1_on <= 1'b0;
    long_frame <= 1'b1;
    wr(2'h2, 8'h00);
    ctl = 8'h98;
    wr(2'h0, ctl);
    tx_frame(8'h81, 1'b1, 11);
    ctl = 8'h90;
    wr(2'h0, ctl);
    tx_frame(8'h7E, 1'b0, 11);
    ctl = 8'hB0;
    wr(2'h0, ctl);
    rx_frame(8'h42, 1'b0, 1'b0, 8'h3C, 1'b0);
    rx_frame(8'hC3, 1'b1, 1'b1, 8'hC3, 1'b1);
    ctl = 8'h80;
    wr(2'h0, ctl);
    rx_frame(8'h11, 1'b1, 1'b0, 8'hC3, 1'b0);
    $display("11-bit fixed test done");
  endtask

  task automatic s_mode3();
    t2_on <= 1'b1;
    wr(2'h3, 8'h30);
    ctl = 8'hD8;
    wr(2'h0, ctl);
    tx_frame(8'h96, 1'b1, 11);
    rx_frame(8'h69, 1'b0, 1'b1, 8'h69, 1'b0);
    wr(2'h0, ctl);
    $display("11-bit timer test done");
  endtask

  task automatic s_raw();
    logic [10:0] bits;
    logic [7:0] v, v2;
    bits = {1'b0, 1'b1, 8'h5A, 1'b0};
    raw_rxd <= 1'b0;
    repeat (12) @(posedge sys_clk);
    raw_rxd <= 1'b1;
    repeat (200) @(posedge sys_clk);
    for (int b = 0; b < 11; b++) begin
      raw_rxd <= bits[b];
      repeat (28) @(posedge sys_clk);
      // Four clocks: one sample wrong at most
      raw_rxd <= ~bits[b];
      repeat (4) @(posedge sys_clk);
      raw_rxd <= bits[b];
      repeat (32) @(posedge sys_clk);
    end
    raw_rxd <= 1'b1;
    repeat (128) @(posedge sys_clk);
    rd(2'h0, v, v2);
    chk("raw flags", 16'h0003, {v2[2], v2[0]});
    chk("raw irq", 1, irq2);
    rd(2'h1, v, v2);
    chk("raw byte", 16'h005A, v2);
    $display("raw line test done");
  endtask

  task automatic final_report();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    s_reset();
    s_mode1();
    s_mode2();
    s_mode3();
    s_raw();
    final_report();
  end

  // Roughly three times the expected run
  initial begin
    repeat (30000) @(posedge sys_clk);
    miscompares++;
    final_report();
  end
endmodule
`default_nettype wire
